// ---- core/sfc_front_end.sv ----
// Purpose: Serial flash command front end: frames, decodes and dispatches.
// Assumes: Host uses modes 0 or 3; link clock is the serial clock pin.
// Notes:   Link logic runs on the serial clock; frame and output state are cleared by chip select.
// Functional notes
// - Four wires: select, clock, data in, data out.
// - Modes 0/3: sample rising, shift falling.
// - Either idle clock level is accepted.
// - All bytes travel most significant bit first.
// - Select release ends the command frame.
// - Unknown opcode starts no operation.
// - After unknown opcode ignore input until reselect.
// - Early select release performs nothing, back idle.
// - Three address bytes; top two bits ignored.
// - Opcode a2 takes two input bits per clock.
// - Opcode 3b drives two output bits per clock.
// - Opcode 02: address, then any number of data bytes.
// - Erase, chip erase, suspend, resume opcodes decoded.
// - Write enable/disable, protect, read protection decoded.
// - Lockdown 33, freeze 34: address, one byte.
// - Opcode 35 returns lockdown bytes after address.
// - Opcode 9b programs secure area with address.
// - Opcode 77: address, two dummies, then data.
// - Status writes 01/31, status read 05.
// - Opcode 9f returns one to seven id bytes (ID_BYTES).
// - Power down b9, wake ab, reset f0.
// - Reads 1b, 0b, 03 with 2, 1, 0 dummies.
`timescale 1ns/1ps
module sfc_front_end #(
    parameter int unsigned ID_BYTES = sfc_pkg::ID_BYTES_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic in_out_pin_i,
    output logic in_out_pin_o,
    output logic in_out_pin_oe,
    input wire logic out_in_pin_i,
    output logic out_in_pin_o,
    output logic out_in_pin_oe,
    output logic cmd_valid,
    output sfc_pkg::sfc_cmd_t cmd,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic rd_req,
    input wire logic [7:0] rd_data,
    output logic frame_end,
    output logic frame_active
);
    import sfc_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The identification byte counter holds at most seven bytes.
    if (ID_BYTES < 1 || ID_BYTES > 7) begin : g_bad_id
        $error("ID_BYTES must lie between 1 and 7");
    end

    // ------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------
    typedef struct packed {
        sfc_phase_t phase;
        logic [4:0] cnt;
        logic [1:0] dleft;
        logic [2:0] bytes;
        logic [7:0] sr;
        logic [7:0] opcode;
        logic [23:0] addr;
        sfc_info_t info;
    } sfc_frame_t;

    typedef struct packed {
        logic hdr_tgl;
        logic wr_tgl;
        logic rd_tgl;
        sfc_cmd_t cmd;
        logic [7:0] wr_byte;
    } sfc_event_t;

    typedef struct packed {
        logic [7:0] sr;
        logic [2:0] cnt;
        logic so;
        logic si;
        logic oe_so;
        logic oe_si;
    } sfc_out_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic cmd_valid;
        sfc_cmd_t cmd;
        logic wr_valid;
        logic [7:0] wr_data;
        logic rd_req;
        logic frame_end;
        logic frame_active;
        logic [7:0] hold;
    } sfc_core_t;

    sfc_frame_t frame_q;
    sfc_frame_t frame_d;
    sfc_event_t ev_q;
    sfc_event_t ev_d;
    sfc_out_t out_q;
    sfc_out_t out_d;
    sfc_core_t core_q;
    sfc_core_t core_d;
    logic link_clr;
    logic hdr_done;
    logic enter_data;
    logic [4:0] top_q;
    logic [4:0] top_d;
    logic [7:0] shifted;
    logic [3:0] edges;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Builds one decode record from its fields.
    function automatic sfc_info_t mk(input logic a, input logic [1:0] dm,
                                     input sfc_dir_t dr, input logic du,
                                     input logic [2:0] mx);
        sfc_info_t r;
        r.valid = 1'b1;
        r.has_addr = a;
        r.dummy = dm;
        r.dir = dr;
        r.dual = du;
        r.max_bytes = mx;
        return r;
    endfunction

    // Maps an opcode to its framing; a zero record marks an unknown one.
    // A max_bytes of zero means the data phase is open ended.
    function automatic sfc_info_t decode(input logic [7:0] op);
        sfc_info_t r;
        r = '0;
        case (op)
            OP_READ_FAST2: r = mk(1'b1, 2'd2, DIR_OUT, 1'b0, 3'd0);
            OP_READ_FAST: r = mk(1'b1, 2'd1, DIR_OUT, 1'b0, 3'd0);
            OP_READ: r = mk(1'b1, 2'd0, DIR_OUT, 1'b0, 3'd0);
            OP_READ_DUAL: r = mk(1'b1, 2'd1, DIR_OUT, 1'b1, 3'd0);
            OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
                r = mk(1'b1, 2'd0, DIR_NONE, 1'b0, 3'd0);
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SUSPEND, OP_RESUME: begin
                r = mk(1'b0, 2'd0, DIR_NONE, 1'b0, 3'd0);
            end
            OP_PROG: r = mk(1'b1, 2'd0, DIR_IN, 1'b0, 3'd0);
            OP_PROG_DUAL: r = mk(1'b1, 2'd0, DIR_IN, 1'b1, 3'd0);
            OP_WR_EN, OP_WR_DIS: begin
                r = mk(1'b0, 2'd0, DIR_NONE, 1'b0, 3'd0);
            end
            OP_PROTECT, OP_UNPROTECT: begin
                r = mk(1'b1, 2'd0, DIR_NONE, 1'b0, 3'd0);
            end
            OP_RD_PROT: r = mk(1'b1, 2'd0, DIR_OUT, 1'b0, 3'd0);
            OP_LOCKDOWN, OP_FREEZE: begin
                r = mk(1'b1, 2'd0, DIR_IN, 1'b0, 3'd1);
            end
            OP_RD_LOCK: r = mk(1'b1, 2'd0, DIR_OUT, 1'b0, 3'd0);
            OP_OTP_PROG: r = mk(1'b1, 2'd0, DIR_IN, 1'b0, 3'd0);
            OP_OTP_READ: r = mk(1'b1, 2'd2, DIR_OUT, 1'b0, 3'd0);
            OP_RD_STATUS: r = mk(1'b0, 2'd0, DIR_OUT, 1'b0, 3'd0);
            OP_WR_STATUS1, OP_WR_STATUS2: begin
                r = mk(1'b0, 2'd0, DIR_IN, 1'b0, 3'd1);
            end
            OP_SW_RESET: r = mk(1'b0, 2'd0, DIR_IN, 1'b0, 3'd1);
            OP_RD_ID: begin
                r = mk(1'b0, 2'd0, DIR_OUT, 1'b0, 3'(ID_BYTES));
            end
            OP_POWER_DOWN, OP_POWER_UP: begin
                r = mk(1'b0, 2'd0, DIR_NONE, 1'b0, 3'd0);
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Link side, rising edge: framing and capture
    // ------------------------------------------------------------------
    // Frame state clears whenever select is high, so no link clock edge
    // is needed after the frame; a released frame simply vanishes.
    assign link_clr = cs_n | rst;

    // Next frame state and event toggles for each rising clock edge.
    always_comb begin
        frame_d = frame_q;
        ev_d = ev_q;
        hdr_done = 1'b0;
        enter_data = 1'b0;
        top_q = frame_q.info.dual ? DUAL_LAST : BYTE_LAST;
        shifted = {frame_q.sr[6:0], in_out_pin_i};
        case (frame_q.phase)
            PH_OPC: begin
                frame_d.sr = shifted;
                frame_d.cnt = frame_q.cnt - 5'd1;
                if (frame_q.cnt == 5'd0) begin
                    frame_d.opcode = shifted;
                    frame_d.info = decode(shifted);
                    if (!frame_d.info.valid) begin
                        frame_d.phase = PH_IGNORE;
                    end else if (frame_d.info.has_addr) begin
                        frame_d.phase = PH_ADDR;
                        frame_d.cnt = ADDR_LAST;
                    end else begin
                        hdr_done = 1'b1;
                        enter_data = 1'b1;
                    end
                end
            end
            PH_ADDR: begin
                frame_d.addr = {frame_q.addr[22:0], in_out_pin_i};
                frame_d.cnt = frame_q.cnt - 5'd1;
                if (frame_q.cnt == 5'd0) begin
                    hdr_done = 1'b1;
                    if (frame_q.info.dummy != 2'd0) begin
                        frame_d.phase = PH_DUMMY;
                        frame_d.cnt = BYTE_LAST;
                        frame_d.dleft = frame_q.info.dummy - 2'd1;
                    end else begin
                        enter_data = 1'b1;
                    end
                end
            end
            PH_DUMMY: begin
                frame_d.cnt = frame_q.cnt - 5'd1;
                if (frame_q.cnt == 5'd0) begin
                    if (frame_q.dleft == 2'd0) begin
                        enter_data = 1'b1;
                    end else begin
                        frame_d.dleft = frame_q.dleft - 2'd1;
                        frame_d.cnt = BYTE_LAST;
                    end
                end
            end
            PH_WR: begin
                if (frame_q.info.dual) begin
                    // The data-out pin carries the higher bit of each pair.
                    frame_d.sr = {frame_q.sr[5:0], out_in_pin_i,
                                  in_out_pin_i};
                end else begin
                    frame_d.sr = shifted;
                end
                frame_d.cnt = frame_q.cnt - 5'd1;
                if (frame_q.cnt == 5'd0) begin
                    ev_d.wr_tgl = ~ev_q.wr_tgl;
                    ev_d.wr_byte = frame_d.sr;
                    frame_d.cnt = top_q;
                    frame_d.bytes = frame_q.bytes + 3'd1;
                    if (frame_q.info.max_bytes != 3'd0 &&
                        frame_d.bytes == frame_q.info.max_bytes) begin
                        frame_d.phase = PH_IGNORE;
                    end
                end
            end
            PH_RD: begin
                frame_d.cnt = frame_q.cnt - 5'd1;
                // Ask for the following byte while this one is shifting.
                if (frame_q.cnt == top_q) begin
                    ev_d.rd_tgl = ~ev_q.rd_tgl;
                end
                if (frame_q.cnt == 5'd0) begin
                    frame_d.cnt = top_q;
                    frame_d.bytes = frame_q.bytes + 3'd1;
                    if (frame_q.info.max_bytes != 3'd0 &&
                        frame_d.bytes == frame_q.info.max_bytes) begin
                        frame_d.phase = PH_IGNORE;
                    end
                end
            end
            PH_IGNORE: begin
                frame_d.phase = PH_IGNORE;
            end
            default: begin
                frame_d.phase = PH_IGNORE;
            end
        endcase
        // Opens the data phase in the direction the command needs.
        top_d = frame_d.info.dual ? DUAL_LAST : BYTE_LAST;
        if (enter_data) begin
            frame_d.cnt = top_d;
            frame_d.bytes = 3'd0;
            case (frame_d.info.dir)
                DIR_OUT: frame_d.phase = PH_RD;
                DIR_IN: frame_d.phase = PH_WR;
                default: frame_d.phase = PH_IGNORE;
            endcase
        end
        // Publishes the finished header; upper address bits are dropped.
        if (hdr_done) begin
            ev_d.hdr_tgl = ~ev_q.hdr_tgl;
            ev_d.cmd.opcode = frame_d.opcode;
            ev_d.cmd.addr = frame_d.addr & ADDR_KEEP;
            if (frame_d.info.dir == DIR_OUT) begin
                ev_d.rd_tgl = ~ev_q.rd_tgl;
            end
        end
    end

    // Frame state samples on the rising edge only, so the idle clock
    // level before the first edge does not matter.
    always_ff @(posedge sck or posedge link_clr) begin
        if (link_clr) begin
            frame_q <= '{phase: PH_OPC, cnt: BYTE_LAST, info: '0,
                         default: '0};
        end else begin
            frame_q <= frame_d;
        end
    end

    // Event toggles survive the end of a frame; only reset clears them.
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_d;
        end
    end

    // ------------------------------------------------------------------
    // Link side, falling edge: serial output
    // ------------------------------------------------------------------
    // Loads a byte from the hold register and shifts it out, one or two
    // bits per falling edge; pins float outside the read data phase.
    always_comb begin
        out_d = out_q;
        if (frame_q.phase == PH_RD) begin
            out_d.oe_so = 1'b1;
            out_d.oe_si = frame_q.info.dual;
            if (out_q.cnt == 3'd0) begin
                out_d.so = core_q.hold[7];
                out_d.si = core_q.hold[6];
                out_d.cnt = frame_q.info.dual ? 3'(DUAL_LAST)
                                              : 3'(BYTE_LAST);
                out_d.sr = frame_q.info.dual ? {core_q.hold[5:0], 2'h0}
                                             : {core_q.hold[6:0], 1'h0};
            end else begin
                out_d.so = out_q.sr[7];
                out_d.si = out_q.sr[6];
                out_d.cnt = out_q.cnt - 3'd1;
                out_d.sr = frame_q.info.dual ? {out_q.sr[5:0], 2'h0}
                                             : {out_q.sr[6:0], 1'h0};
            end
        end else begin
            out_d.oe_so = 1'b0;
            out_d.oe_si = 1'b0;
            out_d.cnt = 3'd0;
        end
    end

    // Output bits change on the falling edge of the serial clock.
    always_ff @(negedge sck or posedge link_clr) begin
        if (link_clr) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    // ------------------------------------------------------------------
    // Core side: crossing and dispatch
    // ------------------------------------------------------------------
    // Edges are taken between the second and third stages only.
    assign edges = core_q.s2 ^ core_q.s3;

    // Synchronises select and the toggles, then issues one-cycle pulses.
    // Header and data words were frozen on the same edge that moved their toggle.
    always_comb begin
        core_d = core_q;
        core_d.s1 = {cs_n, ev_q.hdr_tgl, ev_q.wr_tgl, ev_q.rd_tgl};
        core_d.s2 = core_q.s1;
        core_d.s3 = core_q.s2;
        core_d.cmd_valid = edges[2];
        core_d.wr_valid = edges[1];
        core_d.rd_req = edges[0];
        core_d.frame_end = edges[SYNC_CS] & core_q.s2[SYNC_CS];
        core_d.frame_active = ~core_q.s2[SYNC_CS];
        core_d.hold = rd_data;
        if (edges[2]) begin
            core_d.cmd = ev_q.cmd;
        end
        if (edges[1]) begin
            core_d.wr_data = ev_q.wr_byte;
        end
    end

    // Core registers on the system clock with synchronous reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            core_q <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST,
                        default: '0};
        end else begin
            core_q <= core_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a flip-flop of one of the state records.
    assign out_in_pin_o = out_q.so;
    assign out_in_pin_oe = out_q.oe_so;
    assign in_out_pin_o = out_q.si;
    assign in_out_pin_oe = out_q.oe_si;
    assign cmd_valid = core_q.cmd_valid;
    assign cmd = core_q.cmd;
    assign wr_valid = core_q.wr_valid;
    assign wr_data = core_q.wr_data;
    assign rd_req = core_q.rd_req;
    assign frame_end = core_q.frame_end;
    assign frame_active = core_q.frame_active;

endmodule

// ---- core/sfc_pkg.sv ----
// Purpose: Shared constants and types of the serial flash command front end.
// Assumes: Opcodes, field widths and counts are fixed by the flash command set.
// Notes:   All link-side and core-side records travel as packed structs.
package sfc_pkg;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_READ_FAST2 = 8'h1b;
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ_DUAL = 8'h3b;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
    localparam logic [7:0] OP_SUSPEND = 8'hb0;
    localparam logic [7:0] OP_RESUME = 8'hd0;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_PROTECT = 8'h36;
    localparam logic [7:0] OP_UNPROTECT = 8'h39;
    localparam logic [7:0] OP_RD_PROT = 8'h3c;
    localparam logic [7:0] OP_LOCKDOWN = 8'h33;
    localparam logic [7:0] OP_FREEZE = 8'h34;
    localparam logic [7:0] OP_RD_LOCK = 8'h35;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam logic [7:0] OP_OTP_READ = 8'h77;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS1 = 8'h01;
    localparam logic [7:0] OP_WR_STATUS2 = 8'h31;
    localparam logic [7:0] OP_SW_RESET = 8'hf0;
    localparam logic [7:0] OP_RD_ID = 8'h9f;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_POWER_UP = 8'hab;

    // ------------------------------------------------------------------
    // Field positions, counts and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_LAST = 5'd23;
    localparam logic [4:0] BYTE_LAST = 5'd7;
    localparam logic [4:0] DUAL_LAST = 5'd3;
    localparam logic [23:0] ADDR_KEEP = 24'h3fffff;
    localparam int unsigned ID_BYTES_DEF = 4;
    localparam logic [3:0] SYNC_RST = 4'h8;
    localparam int unsigned SYNC_CS = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_NONE = 2'h0,
        DIR_IN = 2'h1,
        DIR_OUT = 2'h2
    } sfc_dir_t;

    typedef enum logic [5:0] {
        PH_OPC = 6'h01,
        PH_ADDR = 6'h02,
        PH_DUMMY = 6'h04,
        PH_WR = 6'h08,
        PH_RD = 6'h10,
        PH_IGNORE = 6'h20
    } sfc_phase_t;

    typedef struct packed {
        logic valid;
        logic has_addr;
        logic [1:0] dummy;
        sfc_dir_t dir;
        logic dual;
        logic [2:0] max_bytes;
    } sfc_info_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
    } sfc_cmd_t;

endpackage

// ---- tb/sfc_fe_assertions.sv ----
// Purpose: Concurrent checks on the front end core-side ports and pin enables.
// Assumes: Core clock domain only; rst is synchronous and active high.
// Notes:   Bound into the front end by the testbench.
`timescale 1ns/1ps
module sfc_fe_assertions #(
    parameter int unsigned ID_BYTES = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic in_out_pin_oe,
    input wire logic out_in_pin_oe,
    input wire logic cmd_valid,
    input wire sfc_pkg::sfc_cmd_t cmd,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    input wire logic frame_end
);
    import sfc_pkg::*;
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // A strobe is gone on the next core cycle.
    sequence s_drop(sig);
        ##1 !sig;
    endsequence
    property p_addr_top; cmd_valid |-> cmd.addr[23:22] == 2'h0; endproperty
    a_addr_top: assert property (p_addr_top)
        else $error("address top bits passed on");
    property p_cv_one; cmd_valid |-> s_drop(cmd_valid); endproperty
    a_cv_one: assert property (p_cv_one)
        else $error("header strobe longer than one cycle");
    property p_wv_one; wr_valid |-> s_drop(wr_valid); endproperty
    a_wv_one: assert property (p_wv_one)
        else $error("write strobe longer than one cycle");
    property p_rq_one; rd_req |-> s_drop(rd_req); endproperty
    a_rq_one: assert property (p_rq_one)
        else $error("read request longer than one cycle");
    property p_fe_one; frame_end |-> s_drop(frame_end); endproperty
    a_fe_one: assert property (p_fe_one)
        else $error("frame end longer than one cycle");
    property p_cmd_hold; !cmd_valid |-> $stable(cmd); endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command changed without strobe");
    property p_wd_hold; !wr_valid |-> $stable(wr_data); endproperty
    a_wd_hold: assert property (p_wd_hold)
        else $error("write data changed without strobe");
    property p_oe_idle;
        cs_n [*3] |-> !out_in_pin_oe && !in_out_pin_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("pin driven while deselected");
    property p_dual_oe; in_out_pin_oe |-> out_in_pin_oe; endproperty
    a_dual_oe: assert property (p_dual_oe)
        else $error("second output without first");
endmodule

// ---- tb/sfc_host.sv ----
// Purpose: Behavioural serial master driving the front end link pins.
// Assumes: Modes 0 and 3 with a 15 ns serial clock period.
// Notes:   Unused data lines toggle so stale values never look valid.
`timescale 1ns/1ps
module sfc_host (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    output logic hd,
    input wire logic miso,
    input wire logic mio
);
    logic idle;
    // ------------------------------------------------------------------
    // Frame tasks
    // ------------------------------------------------------------------
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        hd = 1'b0;
        idle = 1'b0;
    end
    // Selects the device, clock at its resting level.
    task automatic go(input logic m3);
        idle = m3;
        sck = m3;
        #1.3;
        cs_n = 1'b0;
        #7.5;
    endtask
    // Shifts a byte on one wire or two, high bit first.
    task automatic xb(input logic [7:0] t, input logic du,
        output logic [7:0] r);
        for (int i = 0; i < (du ? 4 : 8); i++) begin
            sck = 1'b0;
            hd = du ? t[7 - 2 * i] : ~hd;
            mosi = du ? t[6 - 2 * i] : t[7 - i];
            #7.5;
            sck = 1'b1;
            if (du) begin
                r[7 - 2 * i] = miso;
                r[6 - 2 * i] = mio;
            end else begin
                r[7 - i] = miso;
            end
            #7.5;
        end
    endtask
    // Ends the frame and leaves the clock still.
    task automatic stop();
        sck = idle;
        #7.5;
        cs_n = 1'b1;
        mosi = ~mosi;
        #60;
    endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the serial flash command front end.
// Assumes: Host model on the link, bench answers read requests.
// Notes:   ID byte count cut to two.
`timescale 1ns/1ps
module testbench;
    import sfc_pkg::*;
    logic clock, rst, sck, cs_n, mosi, hd;
    logic in_out_pin_o, in_out_pin_oe, out_in_pin_o, out_in_pin_oe;
    logic cmd_valid, wr_valid, rd_req, frame_end, frame_active;
    logic [7:0] wr_data, rd_data, r;
    sfc_cmd_t cmd;
    wire io_w = in_out_pin_oe ? in_out_pin_o : mosi;
    wire oi_w = out_in_pin_oe ? out_in_pin_o : hd;
    int errors = 0, n_compared = 0;
    int n_fe = 0, cyc = 0;
    sfc_cmd_t cq[$];
    logic [7:0] wq[$];
    localparam logic [23:0] addr_c = 24'hc5a3e1;
    sfc_front_end #(.ID_BYTES(2)) dut (.clock, .rst, .sck, .cs_n,
        .in_out_pin_i(io_w), .in_out_pin_o, .in_out_pin_oe,
        .out_in_pin_i(oi_w), .out_in_pin_o, .out_in_pin_oe, .cmd_valid,
        .cmd, .wr_valid, .wr_data, .rd_req, .rd_data, .frame_end,
        .frame_active);
    sfc_host host (.sck, .cs_n, .mosi, .hd, .miso(oi_w), .mio(io_w));
    // ------------------------------------------------------------------
    // Clock, monitor and helpers
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Collects core events; cuts a hang short.
    always @(negedge clock) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) cq.push_back(cmd);
        if (wr_valid === 1'b1) wq.push_back(wr_data);
        if (frame_end === 1'b1) n_fe <= n_fe + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    // Each read request offers the next byte.
    always @(negedge clock) if (rd_req === 1'b1) rd_data <= rd_data + 8'h11;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hdr(input logic [7:0] op, input logic na, input logic m3);
        cq.delete();
        wq.delete();
        @(negedge clock);
        n_fe = 0;
        host.go(m3);
        host.xb(op, 1'b0, r);
        if (na) for (int i = 2; i >= 0; i--) host.xb(addr_c[8*i +: 8], 1'b0, r);
    endtask
    task automatic tail(input logic [7:0] op, input logic na, input int nc,
        input int nw);
        chk(frame_active, 1);
        host.stop();
        repeat (12) @(negedge clock);
        chk(frame_active, 0);
        chk(cq.size(), nc);
        chk(wq.size(), nw);
        chk(n_fe, 1);
        if (nc > 0) chk(cq[0], {op, na ? addr_c & ADDR_KEEP : 24'h0});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_nodata();
        logic [7:0] ops[13] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
            OP_PROTECT, OP_UNPROTECT, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B,
            OP_SUSPEND, OP_RESUME, OP_WR_EN, OP_WR_DIS, OP_POWER_DOWN,
            OP_POWER_UP};
        for (int k = 0; k < 13; k++) begin
            hdr(ops[k], k < 5, k[0]);
            host.xb(8'h96, 1'b0, r);
            tail(ops[k], k < 5, 1, 0);
        end
        $display("no-data commands done");
    endtask
    task automatic t_write();
        logic [7:0] ops[8] = '{OP_PROG, OP_PROG_DUAL, OP_OTP_PROG,
            OP_LOCKDOWN, OP_FREEZE, OP_WR_STATUS1, OP_WR_STATUS2, OP_SW_RESET};
        for (int k = 0; k < 8; k++) begin
            hdr(ops[k], k < 5, k[0]);
            for (int i = 0; i < 2; i++) host.xb(8'(8'h81 + 8'h22 * i), k == 1, r);
            tail(ops[k], k < 5, 1, k < 3 ? 2 : 1);
            for (int i = 0; i < wq.size(); i++) chk(wq[i], 8'h81 + 8'h22 * i);
        end
        $display("write commands done");
    endtask
    task automatic t_read();
        logic [7:0] ops[9] = '{OP_READ_FAST2, OP_READ_FAST, OP_READ_DUAL,
            OP_OTP_READ, OP_READ, OP_RD_PROT, OP_RD_LOCK, OP_RD_STATUS,
            OP_RD_ID};
        int dum[9] = '{2, 1, 1, 2, 0, 0, 0, 0, 0};
        for (int k = 0; k < 9; k++) begin
            rd_data = 8'h5a;
            hdr(ops[k], k < 7, k[0]);
            repeat (dum[k]) host.xb(8'h00, 1'b0, r);
            for (int i = 1; i <= (k < 4 ? 2 : 1); i++) begin
                host.xb(8'hff, k == 2, r);
                chk(r, k < 4 ? 8'h5a + 8'h11 * i : 8'h5a);
            end
            tail(ops[k], k < 7, 1, 0);
        end
        $display("read commands done");
    endtask
    task automatic t_bad();
        hdr(8'hff, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) host.xb(OP_PROG, 1'b0, r);
        tail(8'hff, 1'b0, 0, 0);
        hdr(OP_ERASE_4K, 1'b0, 1'b1);
        host.xb(8'h12, 1'b0, r);
        host.xb(8'h34, 1'b0, r);
        tail(OP_ERASE_4K, 1'b0, 0, 0);
        $display("refused frames done");
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Resets the block, then runs each scenario.
    initial begin
        rst = 1'b1;
        rd_data = 8'h00;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (6) @(negedge clock);
        t_nodata();
        t_write();
        t_read();
        t_bad();
        finish_test();
    end
endmodule
bind sfc_front_end sfc_fe_assertions #(.ID_BYTES(ID_BYTES)) u_chk (.clock,
    .rst, .cs_n, .in_out_pin_oe, .out_in_pin_oe, .cmd_valid, .cmd,
    .wr_valid, .wr_data, .rd_req, .frame_end);
